// file: design/smd_pkg.sv
package smd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port geometry and register offsets.
    localparam int SMD_ADDR_W = 8;
    localparam int SMD_DATA_W = 32;
    localparam logic [7:0] SMD_REG_CFG_LO = 8'h00;
    localparam logic [7:0] SMD_REG_CFG_HI = 8'h04;
    localparam logic [7:0] SMD_REG_CTRL = 8'h08;
    localparam logic [7:0] SMD_REG_CMD_ADDR = 8'h0C;
    localparam logic [7:0] SMD_REG_CMD = 8'h10;
    localparam logic [7:0] SMD_REG_CMD_RESULT = 8'h14;
    localparam logic [7:0] SMD_REG_STATUS = 8'h18;
    localparam logic [7:0] SMD_REG_TBL_PTR = 8'h1C;
    localparam logic [7:0] SMD_REG_TBL_DATA = 8'h20;
    localparam logic [7:0] SMD_REG_SECT_QUERY = 8'h24;
    localparam logic [7:0] SMD_REG_SECT_INFO = 8'h28;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int SMD_CTRL_ADDR4 = 0;
    localparam int SMD_CTRL_LAT_LSB = 4;
    localparam int SMD_LAT_W = 4;
    localparam logic [7:0] SMD_CTRL_RESET = 8'h01;
    localparam logic [7:0] SMD_CFG_RESET = 8'h08;
    localparam int SMD_ST_IDX_LSB = 0;
    localparam int SMD_ST_VALID = 2;
    localparam int SMD_ST_BUSY = 3;
    localparam int SMD_ST_ERR_CMD = 8;
    localparam int SMD_ST_ERR_CFG = 9;
    localparam int SMD_RES_ARCH = 8;
    localparam int SMD_SI_PARAM = 8;
    localparam int SMD_SI_VALID = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Detection descriptor fields and command addresses.
    localparam int SMD_ARCH_BIT = 3;
    localparam logic [7:0] SMD_DET_MASK = 8'h08;
    localparam logic [1:0] SMD_DET_ADDR_LEN = 2'h3;
    localparam logic [1:0] SMD_DET_RFU_HI = 2'h3;
    localparam logic [3:0] SMD_DET_LATENCY = 4'hF;
    localparam logic [7:0] SMD_DET_INSTR = 8'h65;
    localparam logic [5:0] SMD_DET_RFU_LO = 6'h3F;
    localparam logic SMD_DET_IS_MAP = 1'b0;
    localparam logic SMD_DET_IS_END = 1'b0;
    localparam logic [31:0] SMD_DET_ADDR_LO = 32'h0000_0004;
    localparam logic [31:0] SMD_DET_ADDR_HI = 32'h0400_0004;
    localparam logic [7:0] SMD_TBL_DESC_LO = 8'h48;
    localparam logic [7:0] SMD_TBL_END = 8'h58;
    localparam logic [7:0] SMD_TBL_BLANK = 8'hFF;
    localparam logic [7:0] SMD_ZERO_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Address map geometry.
    localparam int SMD_DEV_ADDR_W = 27;
    localparam int SMD_PARAM_REGION_LOG2 = 18;
    localparam logic [4:0] SMD_SECT_LOG2_SMALL = 5'h0C;
    localparam logic [4:0] SMD_SECT_LOG2_UNIFORM = 5'h12;

    typedef enum logic [1:0] {
        SMD_MAP_NONE = 2'b00,
        SMD_MAP_BOTTOM = 2'b01,
        SMD_MAP_TOP = 2'b10,
        SMD_MAP_UNIFORM = 2'b11
    } smd_map_kind_type;

    typedef enum logic {
        SMD_CMD_IDLE = 1'b0,
        SMD_CMD_DUMMY = 1'b1
    } smd_cmd_state_type;

    // Architecture bit of a die's configuration byte.
    function automatic logic smd_arch_bit(input logic [7:0] cfg);
        smd_arch_bit = cfg[SMD_ARCH_BIT];
    endfunction

endpackage

// file: design/smd_descriptor_rom.sv
`timescale 1ns/1ps
`default_nettype none
module smd_descriptor_rom
    import smd_pkg::*;
(
    input wire logic [7:0] offset_in,
    output logic [7:0] byte_out
);

    // Detection descriptor dword, assembled from its fields.
    localparam logic [31:0] DET_DWORD = {SMD_DET_MASK, SMD_DET_ADDR_LEN, SMD_DET_RFU_HI,
        SMD_DET_LATENCY, SMD_DET_INSTR, SMD_DET_RFU_LO, SMD_DET_IS_MAP, SMD_DET_IS_END};

    // Little-endian byte lane of a dword.
    function automatic logic [7:0] smd_lane(input logic [31:0] dw, input logic [1:0] sel);
        logic [31:0] sh;
        sh = dw >> {sel, 3'b000};
        smd_lane = sh[7:0];
    endfunction

    always_comb begin
        byte_out = SMD_TBL_BLANK;
        if (offset_in >= SMD_TBL_DESC_LO && offset_in < SMD_TBL_END) begin
            unique case (offset_in[3:2])
                2'b10: byte_out = smd_lane(DET_DWORD, offset_in[1:0]);
                2'b11: byte_out = smd_lane(SMD_DET_ADDR_LO, offset_in[1:0]);
                2'b00: byte_out = smd_lane(DET_DWORD, offset_in[1:0]);
                2'b01: byte_out = smd_lane(SMD_DET_ADDR_HI, offset_in[1:0]);
            endcase
        end
    end

endmodule
`default_nettype wire

// file: design/smd_map_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module smd_map_decoder
    import smd_pkg::*;
#(
    parameter int DEV_ADDR_W = SMD_DEV_ADDR_W,
    parameter int PARAM_LOG2 = SMD_PARAM_REGION_LOG2
) (
    input wire logic [1:0] index_in,
    input wire logic [DEV_ADDR_W-1:0] addr_in,
    output logic valid_out,
    output logic is_param_out,
    output logic [4:0] size_log2_out
);

    logic in_bottom;
    logic in_top;

    assign in_bottom = (addr_in[DEV_ADDR_W-1:PARAM_LOG2] == '0);
    assign in_top = &addr_in[DEV_ADDR_W-1:PARAM_LOG2];

    always_comb begin
        valid_out = 1'b1;
        is_param_out = 1'b0;
        unique case (index_in)
            SMD_MAP_NONE: valid_out = 1'b0;
            SMD_MAP_BOTTOM: is_param_out = in_bottom;
            SMD_MAP_TOP: is_param_out = in_top;
            SMD_MAP_UNIFORM: is_param_out = 1'b0;
        endcase
        size_log2_out = is_param_out ? SMD_SECT_LOG2_SMALL : SMD_SECT_LOG2_UNIFORM;
    end

endmodule
`default_nettype wire

// file: design/smd_sector_map_discovery.sv
`timescale 1ns/1ps
`default_nettype none
module smd_sector_map_discovery
    import smd_pkg::*;
#(
    parameter int DEV_ADDR_W = SMD_DEV_ADDR_W,
    parameter int PARAM_LOG2 = SMD_PARAM_REGION_LOG2
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [SMD_ADDR_W-1:0] reg_addr_in,
    input wire logic [SMD_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [SMD_DATA_W-1:0] reg_rdata_out,
    output logic [1:0] map_index_out,
    output logic map_valid_out,
    output logic cmd_busy_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic [7:0] cfg_lo;
    logic [7:0] cfg_hi;
    logic addr4;
    logic [SMD_LAT_W-1:0] latency;
    logic [31:0] cmd_addr;
    logic [7:0] tbl_ptr;
    logic [DEV_ADDR_W-1:0] sect_query;
    logic err_cmd;
    logic err_cfg;
    smd_cmd_state_type cmd_state;
    logic [SMD_LAT_W-1:0] dummy_cnt;
    logic [7:0] cmd_opcode;
    logic [31:0] cmd_eff_addr;
    logic [7:0] cmd_data;
    logic cmd_arch;
    logic [1:0] map_index;
    logic [7:0] tbl_byte;
    logic dec_valid;
    logic dec_is_param;
    logic [4:0] dec_log2;
    logic [SMD_DATA_W-1:0] rd_word;
    logic wr_cfg_lo;
    logic wr_cfg_hi;
    logic cfg_lo_refused;
    logic cfg_hi_refused;
    logic wr_cmd;
    logic cmd_go;
    logic cmd_exec;
    logic cmd_hit_lo;
    logic cmd_hit_hi;
    logic [7:0] cmd_byte;
    logic clr_err_cmd;
    logic clr_err_cfg;
    logic set_err_cmd;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode.
    assign wr_cfg_lo = reg_wr_in && (reg_addr_in == SMD_REG_CFG_LO);
    assign wr_cfg_hi = reg_wr_in && (reg_addr_in == SMD_REG_CFG_HI);
    assign wr_cmd = reg_wr_in && (reg_addr_in == SMD_REG_CMD);
    assign clr_err_cmd = reg_wr_in && (reg_addr_in == SMD_REG_STATUS)
        && reg_wdata_in[SMD_ST_ERR_CMD];
    assign clr_err_cfg = reg_wr_in && (reg_addr_in == SMD_REG_STATUS)
        && reg_wdata_in[SMD_ST_ERR_CFG];

    // A write that would leave both dies hybrid is refused.
    assign cfg_lo_refused = wr_cfg_lo && !smd_arch_bit(reg_wdata_in[7:0])
        && !smd_arch_bit(cfg_hi);
    assign cfg_hi_refused = wr_cfg_hi && !smd_arch_bit(reg_wdata_in[7:0])
        && !smd_arch_bit(cfg_lo);

    ////////////////////////////////////////////////////////////////////////////
    // Per-die nonvolatile configuration byte three.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_lo <= SMD_CFG_RESET;
            cfg_hi <= SMD_CFG_RESET;
        end else begin
            if (wr_cfg_lo && !cfg_lo_refused) begin
                cfg_lo <= reg_wdata_in[7:0];
            end
            if (wr_cfg_hi && !cfg_hi_refused) begin
                cfg_hi <= reg_wdata_in[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control: address length and dummy latency used by detection reads.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            addr4 <= SMD_CTRL_RESET[SMD_CTRL_ADDR4];
            latency <= SMD_CTRL_RESET[SMD_CTRL_LAT_LSB +: SMD_LAT_W];
            cmd_addr <= '0;
        end else begin
            if (reg_wr_in && reg_addr_in == SMD_REG_CTRL) begin
                addr4 <= reg_wdata_in[SMD_CTRL_ADDR4];
                latency <= reg_wdata_in[SMD_CTRL_LAT_LSB +: SMD_LAT_W];
            end
            if (reg_wr_in && reg_addr_in == SMD_REG_CMD_ADDR) begin
                cmd_addr <= reg_wdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Map index from the two architecture bits, lower die first.
    assign map_index = {smd_arch_bit(cfg_lo), smd_arch_bit(cfg_hi)};

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            map_index_out <= SMD_MAP_UNIFORM;
            map_valid_out <= 1'b1;
        end else begin
            map_index_out <= map_index;
            map_valid_out <= (map_index != SMD_MAP_NONE);
        end
    end

    smd_map_decoder #(
        .DEV_ADDR_W(DEV_ADDR_W),
        .PARAM_LOG2(PARAM_LOG2)
    ) u_decoder (
        .index_in(map_index),
        .addr_in(sect_query),
        .valid_out(dec_valid),
        .is_param_out(dec_is_param),
        .size_log2_out(dec_log2)
    );

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sect_query <= '0;
        end else if (reg_wr_in && reg_addr_in == SMD_REG_SECT_QUERY) begin
            sect_query <= reg_wdata_in[DEV_ADDR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Discovery table: reading the data port advances the pointer.
    smd_descriptor_rom u_rom (
        .offset_in(tbl_ptr),
        .byte_out(tbl_byte)
    );

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tbl_ptr <= SMD_TBL_DESC_LO;
        end else if (reg_wr_in && reg_addr_in == SMD_REG_TBL_PTR) begin
            tbl_ptr <= reg_wdata_in[7:0];
        end else if (reg_rd_in && reg_addr_in == SMD_REG_TBL_DATA) begin
            tbl_ptr <= tbl_ptr + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Detection read engine: opcode, address, dummy cycles, then data.
    assign cmd_go = wr_cmd && (cmd_state == SMD_CMD_IDLE);
    assign cmd_exec = (cmd_state == SMD_CMD_DUMMY) && (dummy_cnt == '0);
    assign cmd_hit_lo = (cmd_opcode == SMD_DET_INSTR) && (cmd_eff_addr == SMD_DET_ADDR_LO);
    assign cmd_hit_hi = (cmd_opcode == SMD_DET_INSTR) && (cmd_eff_addr == SMD_DET_ADDR_HI);
    assign cmd_byte = cmd_hit_lo ? cfg_lo : (cmd_hit_hi ? cfg_hi : SMD_ZERO_BYTE);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cmd_state <= SMD_CMD_IDLE;
            dummy_cnt <= '0;
            cmd_opcode <= '0;
            cmd_eff_addr <= '0;
            cmd_busy_out <= 1'b0;
        end else begin
            unique case (cmd_state)
                SMD_CMD_IDLE: begin
                    if (cmd_go) begin
                        cmd_opcode <= reg_wdata_in[7:0];
                        // Three-byte mode clears the die-select byte.
                        cmd_eff_addr <= addr4 ? cmd_addr
                            : {SMD_ZERO_BYTE, cmd_addr[23:0]};
                        dummy_cnt <= latency;
                        cmd_state <= SMD_CMD_DUMMY;
                        cmd_busy_out <= 1'b1;
                    end
                end
                SMD_CMD_DUMMY: begin
                    if (dummy_cnt == '0) begin
                        cmd_state <= SMD_CMD_IDLE;
                        cmd_busy_out <= 1'b0;
                    end else begin
                        dummy_cnt <= dummy_cnt - SMD_LAT_W'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cmd_data <= '0;
            cmd_arch <= 1'b0;
        end else if (cmd_exec) begin
            cmd_data <= cmd_byte;
            cmd_arch <= |(cmd_byte & SMD_DET_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky error flags; a new event wins over a clear in the same cycle.
    assign set_err_cmd = (cmd_exec && !cmd_hit_lo && !cmd_hit_hi)
        || (wr_cmd && cmd_state != SMD_CMD_IDLE);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            err_cmd <= 1'b0;
            err_cfg <= 1'b0;
        end else begin
            err_cmd <= set_err_cmd || (err_cmd && !clr_err_cmd);
            err_cfg <= cfg_lo_refused || cfg_hi_refused || (err_cfg && !clr_err_cfg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped offsets read zero.
    always_comb begin
        rd_word = '0;
        unique case (reg_addr_in)
            SMD_REG_CFG_LO: rd_word[7:0] = cfg_lo;
            SMD_REG_CFG_HI: rd_word[7:0] = cfg_hi;
            SMD_REG_CTRL: begin
                rd_word[SMD_CTRL_ADDR4] = addr4;
                rd_word[SMD_CTRL_LAT_LSB +: SMD_LAT_W] = latency;
            end
            SMD_REG_CMD_ADDR: rd_word = cmd_addr;
            SMD_REG_CMD_RESULT: begin
                rd_word[7:0] = cmd_data;
                rd_word[SMD_RES_ARCH] = cmd_arch;
            end
            SMD_REG_STATUS: begin
                rd_word[SMD_ST_IDX_LSB +: 2] = map_index;
                rd_word[SMD_ST_VALID] = dec_valid;
                rd_word[SMD_ST_BUSY] = cmd_busy_out;
                rd_word[SMD_ST_ERR_CMD] = err_cmd;
                rd_word[SMD_ST_ERR_CFG] = err_cfg;
            end
            SMD_REG_TBL_PTR: rd_word[7:0] = tbl_ptr;
            SMD_REG_TBL_DATA: rd_word[7:0] = tbl_byte;
            SMD_REG_SECT_QUERY: rd_word[DEV_ADDR_W-1:0] = sect_query;
            SMD_REG_SECT_INFO: begin
                rd_word[4:0] = dec_log2;
                rd_word[SMD_SI_PARAM] = dec_is_param;
                rd_word[SMD_SI_VALID] = dec_valid;
            end
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_word;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_rd_tbl_at_desc;
        reg_rd_in && reg_addr_in == SMD_REG_TBL_DATA && tbl_ptr == SMD_TBL_DESC_LO;
    endsequence

    sequence s_go_lat2;
        cmd_go && latency == 4'h2;
    endsequence

    sequence s_go_detect_lo;
        cmd_go && latency == 4'h0 && addr4 && reg_wdata_in[7:0] == 8'h65
            && cmd_addr == 32'h0000_0004;
    endsequence

    sequence s_go_detect_hi;
        cmd_go && latency == 4'h0 && addr4 && reg_wdata_in[7:0] == 8'h65
            && cmd_addr == 32'h0400_0004;
    endsequence

    AST_INDEX_LOW_DIE_MSB: assert property (
        wr_cfg_lo && !cfg_lo_refused |-> ##2 map_index_out[1] == $past(reg_wdata_in[3], 2))
        else $error("Lower die bit did not reach the index MSB.");

    AST_ARCH_BIT_SENSE: assert property (
        wr_cfg_hi && !cfg_hi_refused && !reg_wdata_in[3] |=> ##1 map_index_out == 2'b10)
        else $error("Hybrid upper die did not give index 02h.");

    AST_BOTTOM_MAP: assert property (
        map_index == 2'b01 |-> dec_valid
            && (dec_is_param == (sect_query[DEV_ADDR_W-1:PARAM_LOG2] == '0))
            && dec_log2 == (dec_is_param ? 5'h0C : 5'h12))
        else $error("Bottom map decoded wrongly.");

    AST_TOP_MAP: assert property (
        map_index == 2'b10 |-> dec_is_param == (&sect_query[DEV_ADDR_W-1:PARAM_LOG2]))
        else $error("Top map decoded wrongly.");

    AST_UNIFORM_MAP: assert property (
        map_index == 2'b11 |-> !dec_is_param && dec_log2 == 5'h12)
        else $error("Uniform map reported a small sector.");

    AST_NEVER_BOTH_HYBRID: assert property (
        (cfg_lo_refused || cfg_hi_refused) |=> map_index_out != 2'b00 && err_cfg)
        else $error("Both dies were allowed to be hybrid.");

    AST_TABLE_FIRST_BYTE: assert property (
        s_rd_tbl_at_desc |=> reg_rdata_out == 32'h0000_00FC)
        else $error("Descriptor first byte is not FCh.");

    AST_TABLE_DWORD: assert property (
        tbl_ptr == 8'h48 || tbl_ptr == 8'h50 |-> tbl_byte[1:0] == 2'b00)
        else $error("Descriptor type bits are not zero.");

    AST_INSTR_FIELD: assert property (
        tbl_ptr == 8'h49 || tbl_ptr == 8'h51 |-> tbl_byte == 8'h65)
        else $error("Descriptor instruction is not 65h.");

    AST_RESERVED_ONES: assert property (
        tbl_ptr == 8'h50 |-> tbl_byte[7:2] == 6'h3F && tbl_byte[1:0] == 2'b00)
        else $error("Reserved descriptor bits not all ones.");

    AST_MASK_FIELD: assert property (
        tbl_ptr == 8'h4B |-> tbl_byte == 8'h08)
        else $error("Descriptor read mask is not 08h.");

    AST_LATENCY_HOLDS: assert property (
        s_go_lat2 |=> cmd_busy_out [*3] ##1 !cmd_busy_out)
        else $error("Dummy latency not honoured.");

    AST_SHORT_ADDR: assert property (
        cmd_go && !addr4 |=> cmd_eff_addr[31:24] == 8'h00)
        else $error("Three-byte address kept a die-select byte.");

    AST_DETECT_LOW_DIE: assert property (
        s_go_detect_lo |-> ##2 cmd_data == $past(cfg_lo) && cmd_arch == $past(cfg_lo[3]))
        else $error("Lower die detection returned wrong data.");

    AST_DETECT_HIGH_DIE: assert property (
        s_go_detect_hi |-> ##2 cmd_data == $past(cfg_hi) && cmd_arch == $past(cfg_hi[3]))
        else $error("Upper die detection returned wrong data.");

endmodule
`default_nettype wire

// file: dv/smd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smd_host_model
    import smd_pkg::*;
(
    input wire logic clk_in,
    input wire logic busy_in,
    input wire logic [SMD_DATA_W-1:0] rdata_in,
    output logic [SMD_ADDR_W-1:0] addr_out,
    output logic [SMD_DATA_W-1:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = '0;
        wdata_out = '0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Released lines show the inverse of the last value, never a stale copy.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
    // Issues a detection read and counts the cycles of its dummy phase.
    task automatic detect(input logic [31:0] a, input logic [7:0] op, output int n);
        wr(SMD_REG_CMD_ADDR, a);
        wr(SMD_REG_CMD, {24'h0, op});
        n = 0;
        for (int i = 0; i < 40; i++) begin
            #1;
            if (busy_in !== 1'b1) break;
            n++;
            @(posedge clk_in);
        end
    endtask
endmodule
`default_nettype wire

// file: dv/test_sector_map_discovery.sv
`timescale 1ns/1ps
`default_nettype none
module test_sector_map_discovery;
    import smd_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [SMD_ADDR_W-1:0] reg_addr_in;
    logic [SMD_DATA_W-1:0] reg_wdata_in, reg_rdata_out, d;
    logic reg_wr_in, reg_rd_in, map_valid_out, cmd_busy_out, refused;
    logic [1:0] map_index_out;
    logic [31:0] lfsr = 32'h803AFE0E;
    logic [7:0] lo = 8'h08, hi = 8'h08;
    logic [3:0] lat;
    int bad_count = 0, cmp_count = 0, n;
    logic [7:0] reg_list [7] = '{8'h00, 8'h04, 8'h08, 8'h1C, 8'h18, 8'h10, 8'h3C};
    logic [7:0] init_list [7] = '{8'h08, 8'h08, 8'h01, 8'h48, 8'h07, 8'h00, 8'h00};
    logic [26:0] qa [5] = '{27'h0, 27'h3FFFF, 27'h40000, 27'h7FBFFFF, 27'h7FC0000};

    always #12.5 sys_clk_in = ~sys_clk_in;

    smd_sector_map_discovery i_smd_sector_map_discovery (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .map_index_out(map_index_out), .map_valid_out(map_valid_out),
        .cmd_busy_out(cmd_busy_out));
    smd_host_model i_smd_host_model (.clk_in(sys_clk_in), .busy_in(cmd_busy_out),
        .rdata_in(reg_rdata_out), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
        .wr_out(reg_wr_in), .rd_out(reg_rd_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] tbl(input logic [7:0] off);
        case (off)
            8'h48, 8'h50: tbl = 8'hFC;
            8'h49, 8'h51: tbl = 8'h65;
            8'h4A, 8'h52: tbl = 8'hFF;
            8'h4B, 8'h53: tbl = 8'h08;
            8'h4C, 8'h54, 8'h57: tbl = 8'h04;
            8'h4D, 8'h4E, 8'h4F, 8'h55, 8'h56: tbl = 8'h00;
            default: tbl = 8'hFF;
        endcase
    endfunction
    function automatic logic [1:0] exp_index(input logic [7:0] l, input logic [7:0] h);
        return {l[3], h[3]};
    endfunction
    function automatic logic [31:0] exp_sect(input logic [1:0] idx, input logic [26:0] a);
        logic p;
        p = (idx == 2'h1 && a < 27'h40000) || (idx == 2'h2 && a >= 27'h7FC0000);
        return {22'h0, 1'b1, p, 3'h0, p ? 5'h0C : 5'h12};
    endfunction
    // A write that would leave both dies hybrid must be dropped and flagged.
    task automatic set_cfg(input logic [7:0] l, input logic [7:0] h);
        refused = 1'b0;
        i_smd_host_model.wr(SMD_REG_CFG_LO, {24'h0, l});
        if (l[3] | hi[3]) lo = l; else refused = 1'b1;
        i_smd_host_model.wr(SMD_REG_CFG_HI, {24'h0, h});
        if (h[3] | lo[3]) hi = h; else refused = 1'b1;
        i_smd_host_model.rd(SMD_REG_STATUS, d);
        check(d, {22'h0, refused, 6'h0, 1'b1, exp_index(lo, hi)});
        check({29'h0, map_valid_out, map_index_out}, {29'h0, 1'b1, exp_index(lo, hi)});
        i_smd_host_model.rd(SMD_REG_CFG_HI, d);
        check(d, {24'h0, hi});
        if (refused) i_smd_host_model.wr(SMD_REG_STATUS, 32'h0000_0200);
    endtask
    task automatic run_det(input logic [31:0] a, input logic [7:0] op, input logic [7:0] c,
                           input logic ok);
        i_smd_host_model.detect(a, op, n);
        if (ok) check(32'(n), {28'h0, lat} + 32'h1);
        i_smd_host_model.rd(SMD_REG_CMD_RESULT, d);
        check(d, ok ? {23'h0, |(c & SMD_DET_MASK), c} : 32'h0);
        i_smd_host_model.rd(SMD_REG_STATUS, d);
        check({31'h0, d[8]}, {31'h0, ~ok});
        i_smd_host_model.wr(SMD_REG_STATUS, 32'h0000_0100);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        #1;
        check({28'h0, cmd_busy_out, map_valid_out, map_index_out}, 32'h0000_0007);
        for (int i = 0; i < 7; i++) begin
            i_smd_host_model.rd(reg_list[i], d);
            check(d, {24'h0, init_list[i]});
        end
        $display("reset test done");
        i_smd_host_model.wr(SMD_REG_TBL_PTR, 32'h0000_0046);
        for (logic [7:0] off = 8'h46; off < 8'h5A; off++) begin
            i_smd_host_model.rd(SMD_REG_TBL_DATA, d);
            check(d, {24'h0, tbl(off)});
        end
        $display("table test done");
        for (int i = 0; i < 24; i++) begin
            lfsr = next_rand(lfsr);
            if (i < 4) set_cfg({lfsr[7:4], i[1], lfsr[2:0]}, {lfsr[15:12], i[0], lfsr[10:8]});
            else set_cfg(lfsr[7:0], lfsr[15:8]);
            for (int j = 0; j < 5; j++) begin
                i_smd_host_model.wr(SMD_REG_SECT_QUERY, {5'h0, qa[j]});
                i_smd_host_model.rd(SMD_REG_SECT_INFO, d);
                check(d, exp_sect(exp_index(lo, hi), qa[j]));
            end
        end
        $display("map test done");
        for (int i = 0; i < 6; i++) begin
            lfsr = next_rand(lfsr);
            lat = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : (i == 2) ? 4'h2 : lfsr[3:0];
            set_cfg(lfsr[15:8], lfsr[23:16]);
            i_smd_host_model.wr(SMD_REG_CTRL, {24'h0, lat, 4'h1});
            run_det(SMD_DET_ADDR_LO, SMD_DET_INSTR, lo, 1'b1);
            run_det(SMD_DET_ADDR_HI, SMD_DET_INSTR, hi, 1'b1);
        end
        i_smd_host_model.wr(SMD_REG_CTRL, 32'h0000_0031);
        i_smd_host_model.wr(SMD_REG_CMD, {24'h0, SMD_DET_INSTR});
        i_smd_host_model.wr(SMD_REG_CMD, {24'h0, SMD_DET_INSTR});
        i_smd_host_model.rd(SMD_REG_STATUS, d);
        check({30'h0, d[8], d[3]}, 32'h3);
        i_smd_host_model.wr(SMD_REG_STATUS, 32'h0000_0100);
        lat = 4'h0;
        i_smd_host_model.wr(SMD_REG_CTRL, 32'h0000_0000);
        run_det(32'hFF00_0004, SMD_DET_INSTR, lo, 1'b1);
        run_det(32'h0000_0008, SMD_DET_INSTR, lo, 1'b0);
        run_det(SMD_DET_ADDR_LO, 8'h03, lo, 1'b0);
        $display("detection test done");
        complete_run();
    end
endmodule
`default_nettype wire
